// ---- testbench/gpcd_pin_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Board wiring on the pins: pull-ups plus an optional outside driver.
// ------------------------------------------------------------------
module gpcd_pin_model
  import gpcd_pkg::*;
(
  input  wire logic [PIN_W-1:0] pin_out,
  input  wire logic [PIN_W-1:0] pin_oe,
  input  wire logic [PIN_W-1:0] ext_en,
  input  wire logic [PIN_W-1:0] ext_val,
  output logic      [PIN_W-1:0] pin_level
);
  // A released pin with no outside driver floats up, so a stale level never survives.
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule : gpcd_pin_model

// ---- testbench/gpcd_port_asserts.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port-level checks on the register slave and the pin drivers.
// ------------------------------------------------------------------
module gpcd_port_asserts
  import gpcd_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [PIN_W-1:0]  pin_out,
  input wire logic [PIN_W-1:0]  pin_oe,
  input wire logic [PIN_W-1:0]  twi_own,
  input wire logic [PIN_W-1:0]  twi_out,
  input wire logic              irq
);
  // All checks share one clock, so reset is handled once here.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Both halves of a write taken on one edge.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // The answer comes two edges after the take, not on the next one.
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_ready_after_reset;
    $fell(srst) |-> ##[0:1] (s_axi_awready && s_axi_wready && s_axi_arready);
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset) else $error("readies low after reset");
  property p_write_answer;
    s_wr_take |=> s_b_late;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  property p_b_single;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_single: assert property (p_b_single) else $error("write answer repeated");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && (s_axi_rdata[31:8] == 24'h000000);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer bad");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read answer repeated");
  property p_twi_low_only;
    (pin_out & $past(twi_own)) == 8'h00;
  endproperty
  a_twi_low_only: assert property (p_twi_low_only) else $error("owned pin driven high");
  property p_od_release;
    (pin_oe & $past(twi_own) & $past(twi_out)) == 8'h00;
  endproperty
  a_od_release: assert property (p_od_release) else $error("owned pin not released");
  // A sticky flag may only drop by a write, whose answer rises on the same edge.
  property p_irq_fall;
    $fell(irq) |-> s_axi_bvalid;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
endmodule : gpcd_port_asserts

// ---- testbench/gpcd_port_tb.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Self-checking bench: register table rows, then pin and flag cases.
// ------------------------------------------------------------------
module gpcd_port_tb
  import gpcd_pkg::*;
;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } gpcd_row_type;
  logic              core_clk, srst;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, irq;
  logic [PIN_W-1:0]  pin_level, pin_out, pin_oe, pin_slew_limit;
  logic [PIN_W-1:0]  twi_own, twi_out, ext_en, ext_val;
  int                n_mismatch, compares, cycles;
  // Address, write?, data, read-back, response.
  gpcd_row_type      rows [10] = '{
    '{OFS_DIRECTION, 1'b0, 32'h0, 32'hFF, RESP_OKAY},
    '{OFS_RISE_EN, 1'b0, 32'h0, 32'h00, RESP_OKAY},
    '{OFS_FALL_EN, 1'b0, 32'h0, 32'h00, RESP_OKAY},
    '{OFS_CHANGE_FLAG, 1'b0, 32'h0, 32'h00, RESP_OKAY},
    '{OFS_SLEW_LIMIT, 1'b1, 32'hA5, 32'hA5, RESP_OKAY},
    '{OFS_OPEN_DRAIN, 1'b1, 32'hC0, 32'hC0, RESP_OKAY},
    '{OFS_FALL_EN, 1'b1, 32'h3C, 32'h3C, RESP_OKAY},
    '{OFS_INT_MASK, 1'b1, 32'h1, 32'h1, RESP_OKAY},
    '{OFS_RISE_EN, 1'b1, 32'h1FF, 32'hFF, RESP_OKAY},
    '{8'h30, 1'b1, 32'h5, 32'h0, RESP_SLVERR}};

  gpcd_port uut (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in(pin_level),
    .pin_out, .pin_oe, .pin_slew_limit, .twi_own, .twi_out, .irq);
  gpcd_pin_model u_pins (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_level);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er), "write response");
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    chk(s_axi_rdata, e, "read data");
    chk(32'(s_axi_rresp), 32'(er), "read response");
  endtask : rdc

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : settle

  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: the whole run needs well under this many cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    {srst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {twi_own, twi_out, ext_en, ext_val} = '0;
    settle(20);
    srst <= 1'b0;
    settle(2);
    chk(32'(pin_oe), 32'h0, "oe after reset");
    chk(32'(irq), 32'h0, "irq after reset");
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, 4'hF, rows[i].r);
      rdc(rows[i].a, rows[i].e, rows[i].r);
    end
    // Low nibble driven, high nibble from outside, pin 5 analog.
    wr(OFS_DIRECTION, 32'hF0, 4'hF, RESP_OKAY);
    wr(OFS_LATCH, 32'h07, 4'hF, RESP_OKAY);
    wr(OFS_ANALOG_SEL, 32'h20, 4'hF, RESP_OKAY);
    ext_en <= 8'hF0;
    ext_val <= 8'hA0;
    settle(5);
    chk(32'(pin_oe), 32'h0F, "direction");
    chk(32'(pin_out & 8'h0F), 32'h07, "latch on pins");
    chk(32'(pin_slew_limit), 32'hA5, "slew");
    rdc(OFS_PIN_LEVELS, 32'h87, RESP_OKAY);
    wr(OFS_PIN_LEVELS, 32'h0, 4'h0, RESP_OKAY);
    rdc(OFS_LATCH, 32'h87, RESP_OKAY);
    wr(OFS_PIN_LEVELS, 32'h3D, 4'hF, RESP_OKAY);
    rdc(OFS_LATCH, 32'h3D, RESP_OKAY);
    wr(OFS_OPEN_DRAIN, 32'h01, 4'hF, RESP_OKAY);
    settle(3);
    chk(32'(pin_oe), 32'h0E, "open drain high");
    chk(32'(pin_out & 8'h0F), 32'h0C, "push pull");
    twi_own <= 8'h02;
    twi_out <= 8'h02;
    settle(3);
    chk(32'(pin_oe), 32'h0C, "owned pin high");
    twi_out <= 8'h00;
    settle(3);
    chk(32'(pin_oe), 32'h0E, "owned pin low");
    twi_own <= 8'h00;
    // Change detection: rise armed on 0 and 2, fall on 1 and 3.
    wr(OFS_INT_MASK, 32'h0, 4'hF, RESP_OKAY);
    wr(OFS_DIRECTION, 32'hFF, 4'hF, RESP_OKAY);
    wr(OFS_ANALOG_SEL, 32'h0, 4'hF, RESP_OKAY);
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    wr(OFS_RISE_EN, 32'h05, 4'hF, RESP_OKAY);
    wr(OFS_FALL_EN, 32'h0A, 4'hF, RESP_OKAY);
    settle(5);
    wr(OFS_CHANGE_FLAG, 32'h0, 4'hF, RESP_OKAY);
    wr(OFS_INT_STATUS, 32'h1, 4'hF, RESP_OKAY);
    ext_val <= 8'h0F;
    settle(6);
    rdc(OFS_CHANGE_FLAG, 32'h05, RESP_OKAY);
    ext_val <= 8'h00;
    settle(6);
    rdc(OFS_CHANGE_FLAG, 32'h0F, RESP_OKAY);
    rdc(OFS_INT_STATUS, 32'h1, RESP_OKAY);
    chk(32'(irq), 32'h0, "masked irq");
    wr(OFS_INT_MASK, 32'h1, 4'hF, RESP_OKAY);
    settle(3);
    chk(32'(irq), 32'h1, "irq raised");
    wr(OFS_CHANGE_FLAG, 32'hFE, 4'hF, RESP_OKAY);
    rdc(OFS_CHANGE_FLAG, 32'h0E, RESP_OKAY);
    wr(OFS_INT_STATUS, 32'h1, 4'hF, RESP_OKAY);
    settle(3);
    chk(32'(irq), 32'h0, "irq cleared");
    // A second reset in mid-run must restore the register table.
    srst <= 1'b1;
    settle(2);
    srst <= 1'b0;
    settle(2);
    chk(32'(pin_oe), 32'h0, "oe after second reset");
    rdc(OFS_DIRECTION, 32'hFF, RESP_OKAY);
    rdc(OFS_CHANGE_FLAG, 32'h00, RESP_OKAY);
    give_verdict();
  end
endmodule : gpcd_port_tb

bind gpcd_port gpcd_port_asserts u_chk (.core_clk, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_out, .pin_oe,
  .twi_own, .twi_out, .irq);

// ---- verilog/gpcd_edge_sync.sv ----
`timescale 1ns/1ps
// Synchroniser and edge finder for the pin inputs.
module gpcd_edge_sync
  import gpcd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_r,  meta_nxt;   // First stage, read only by stage two.
  logic [WIDTH-1:0] sync_r,  sync_nxt;   // Settled sample.
  logic [WIDTH-1:0] prev_r,  prev_nxt;   // Sample of the cycle before.

  // Next values: a plain shift through three stages.
  always_comb begin
    meta_nxt = raw_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // Registers only. The stages keep sampling through reset, so the history
  // already matches the pins when reset lifts and no false edge follows it.
  always_ff @(posedge core_clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
    prev_r <= prev_nxt;
  end

  // Edges come from comparing the settled sample with the one before.
  // None are reported while reset holds, as the stages may still be filling.
  assign level = sync_r;
  assign rise  = srst ? '0 : (sync_r & ~prev_r);
  assign fall  = srst ? '0 : (~sync_r & prev_r);

endmodule : gpcd_edge_sync

// ---- verilog/gpcd_pin_drive.sv ----
`timescale 1ns/1ps
// Output driver control for one pin.
module gpcd_pin_drive
  import gpcd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  gpcd_pin_ctrl_type      ctrl,
  output gpcd_pin_drv_type       drv
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  gpcd_pin_drv_type drv_r, drv_nxt;   // Registered pad controls.
  logic             val;              // Level the pin should show.
  logic             od_eff;           // Effective open-drain mode.

  // Work out drive level and enable from the controls.
  always_comb begin
    val           = ctrl.twi_own ? ctrl.twi_out : ctrl.lat;
    od_eff        = ctrl.od | ctrl.twi_own;
    drv_nxt.slew  = ctrl.slew;
    if (od_eff) begin
      // Sink only: drive low, release for high.
      drv_nxt.out = 1'b0;
      drv_nxt.oe  = ~ctrl.dir & ~val;
    end else begin
      // Push-pull while the direction bit is clear.
      drv_nxt.out = val;
      drv_nxt.oe  = ~ctrl.dir;
    end
  end

  // Registers only; the pad is released during reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      drv_r <= '0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  assign drv = drv_r;

endmodule : gpcd_pin_drive

// ---- verilog/gpcd_pkg.sv ----
package gpcd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PIN_W  = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_LEVELS  = 8'h00;
  localparam logic [7:0] OFS_DIRECTION   = 8'h04;
  localparam logic [7:0] OFS_LATCH       = 8'h08;
  localparam logic [7:0] OFS_OPEN_DRAIN  = 8'h0C;
  localparam logic [7:0] OFS_SLEW_LIMIT  = 8'h10;
  localparam logic [7:0] OFS_ANALOG_SEL  = 8'h14;
  localparam logic [7:0] OFS_RISE_EN     = 8'h18;
  localparam logic [7:0] OFS_FALL_EN     = 8'h1C;
  localparam logic [7:0] OFS_CHANGE_FLAG = 8'h20;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h24;
  localparam logic [7:0] OFS_INT_MASK    = 8'h28;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIRECTION  = 8'hFF;
  localparam logic [7:0] RST_LATCH      = 8'h00;
  localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
  localparam logic [7:0] RST_SLEW_LIMIT = 8'h00;
  localparam logic [7:0] RST_ANALOG_SEL = 8'h00;
  localparam logic [7:0] RST_EDGE_EN    = 8'h00;
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic       RST_INT_BIT    = 1'b0;
  localparam int         INT_SUMMARY_BIT = 0;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-pin control bundle handed to each pin driver.
  typedef struct packed {
    logic dir;       // One makes the pin an input.
    logic lat;       // Output latch bit.
    logic od;        // Open-drain select.
    logic slew;      // Slew-limit select.
    logic twi_own;   // Two-wire peripheral owns the pin.
    logic twi_out;   // Level the two-wire peripheral wants.
  } gpcd_pin_ctrl_type;

  // Per-pin answer from each pin driver.
  typedef struct packed {
    logic out;
    logic oe;
    logic slew;
  } gpcd_pin_drv_type;

endpackage : gpcd_pkg

// ---- verilog/gpcd_port.sv ----
`timescale 1ns/1ps
// Eight-pin general-purpose port with change detection and an AXI4-Lite
// register slave.
module gpcd_port
  import gpcd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins.
  input  wire logic [PIN_W-1:0]  pin_in,
  output logic      [PIN_W-1:0]  pin_out,
  output logic      [PIN_W-1:0]  pin_oe,
  output logic      [PIN_W-1:0]  pin_slew_limit,
  // Two-wire peripheral pin ownership.
  input  wire logic [PIN_W-1:0]  twi_own,
  input  wire logic [PIN_W-1:0]  twi_out,
  // Interrupt.
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] dir_r,  dir_nxt;    // Direction, one is input.
  logic [PIN_W-1:0] lat_r,  lat_nxt;    // Output latch.
  logic [PIN_W-1:0] od_r,   od_nxt;     // Open-drain select.
  logic [PIN_W-1:0] slew_r, slew_nxt;   // Slew-limit select.
  logic [PIN_W-1:0] ana_r,  ana_nxt;    // Analog select.
  logic [PIN_W-1:0] rise_r, rise_nxt;   // Rising-edge enable.
  logic [PIN_W-1:0] fall_r, fall_nxt;   // Falling-edge enable.
  logic [PIN_W-1:0] flag_r, flag_nxt;   // Per-pin change flags.
  logic             sum_r,  sum_nxt;    // Summary change flag.
  logic             mask_r, mask_nxt;   // Interrupt mask for the summary.
  logic             irq_r,  irq_nxt;    // Registered interrupt line.

  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  logic              aw_full_r, aw_full_nxt;   // Write address held.
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic              w_full_r,  w_full_nxt;    // Write data held.
  logic [DATA_W-1:0] w_data_r,  w_data_nxt;
  logic [3:0]        w_strb_r,  w_strb_nxt;
  logic              bvalid_r,  bvalid_nxt;
  logic [1:0]        bresp_r,   bresp_nxt;
  logic              rvalid_r,  rvalid_nxt;
  logic [DATA_W-1:0] rdata_r,   rdata_nxt;
  logic [1:0]        rresp_r,   rresp_nxt;

  // ----------------------------------------------------------------
  // Pin side
  // ----------------------------------------------------------------
  logic [PIN_W-1:0]  pin_level;   // Synchronised pin levels.
  logic [PIN_W-1:0]  pin_rise;    // One-cycle rising edge seen.
  logic [PIN_W-1:0]  pin_fall;    // One-cycle falling edge seen.
  logic [PIN_W-1:0]  port_read;   // What a port read returns.
  logic [PIN_W-1:0]  events;      // Enabled edges this cycle.
  gpcd_pin_drv_type  drv [PIN_W];

  // Pin samples pass a two-stage synchroniser before anyone looks.
  gpcd_edge_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .raw_in   (pin_in),
    .level    (pin_level),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  // One driver per pin; each output is registered inside.
  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    gpcd_pin_drive u_drv (
      .core_clk (core_clk),
      .srst     (srst),
      .ctrl     (gpcd_pin_ctrl_type'{dir: dir_r[i], lat: lat_r[i], od: od_r[i],
                   slew: slew_r[i], twi_own: twi_own[i], twi_out: twi_out[i]}),
      .drv      (drv[i])
    );
    assign pin_out[i]        = drv[i].out;
    assign pin_oe[i]         = drv[i].oe;
    assign pin_slew_limit[i] = drv[i].slew;
  end

  // Analog pins read zero; their drivers still follow direction.
  assign port_read = pin_level & ~ana_r;

  // Each pin flags only the edges its enables arm.
  assign events = (pin_rise & rise_r) | (pin_fall & fall_r);

  // ----------------------------------------------------------------
  // Write channel handling
  // ----------------------------------------------------------------
  logic wr_go;   // Address and data both held, no answer pending.
  logic rd_go;   // Read address taken this cycle.
  assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
  assign rd_go = s_axi_arvalid & ~rvalid_r;

  // Take address and data in either order, answer once both are in.
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_addr_nxt = aw_addr_r;
    w_full_nxt  = w_full_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && !aw_full_r) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_r) begin
      w_full_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      // Unmapped or misaligned addresses get a slave error.
      unique case (aw_addr_r)
        OFS_PIN_LEVELS, OFS_DIRECTION, OFS_LATCH, OFS_OPEN_DRAIN,
        OFS_SLEW_LIMIT, OFS_ANALOG_SEL, OFS_RISE_EN, OFS_FALL_EN,
        OFS_CHANGE_FLAG, OFS_INT_STATUS, OFS_INT_MASK: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file next values
  // ----------------------------------------------------------------
  logic             wr_lane;    // Low byte lane is written.
  logic [PIN_W-1:0] wbyte;      // Low byte of the held data.
  logic [PIN_W-1:0] flag_clr;   // Flags software clears now.
  logic             sum_clr;    // Summary cleared by writing one.
  assign wr_lane = wr_go & w_strb_r[0];
  assign wbyte   = w_data_r[PIN_W-1:0];

  // Software writes first, then hardware sets; a set always wins.
  always_comb begin
    dir_nxt  = dir_r;
    lat_nxt  = lat_r;
    od_nxt   = od_r;
    slew_nxt = slew_r;
    ana_nxt  = ana_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    mask_nxt = mask_r;
    flag_clr = '0;
    sum_clr  = 1'b0;
    if (wr_go) begin
      unique case (aw_addr_r)
        OFS_PIN_LEVELS: begin
          // Store the written byte in the latch, or the pin reading if the low lane is not strobed.
          lat_nxt = w_strb_r[0] ? wbyte : port_read;
        end
        OFS_LATCH: begin
          if (wr_lane) lat_nxt = wbyte;
        end
        OFS_DIRECTION: begin
          if (wr_lane) dir_nxt = wbyte;
        end
        OFS_OPEN_DRAIN: begin
          if (wr_lane) od_nxt = wbyte;
        end
        OFS_SLEW_LIMIT: begin
          if (wr_lane) slew_nxt = wbyte;
        end
        OFS_ANALOG_SEL: begin
          if (wr_lane) ana_nxt = wbyte;
        end
        OFS_RISE_EN: begin
          if (wr_lane) rise_nxt = wbyte;
        end
        OFS_FALL_EN: begin
          if (wr_lane) fall_nxt = wbyte;
        end
        OFS_CHANGE_FLAG: begin
          // A zero written clears; a one leaves the flag alone.
          if (wr_lane) flag_clr = ~wbyte;
        end
        OFS_INT_STATUS: begin
          if (wr_lane) sum_clr = wbyte[INT_SUMMARY_BIT];
        end
        OFS_INT_MASK: begin
          if (wr_lane) mask_nxt = wbyte[INT_SUMMARY_BIT];
        end
        default: begin
          // Unmapped writes change nothing.
        end
      endcase
    end
    // Flags set on any armed edge, whatever the interrupt mask holds.
    flag_nxt = (flag_r & ~flag_clr) | events;
    sum_nxt  = (sum_r & ~sum_clr) | (|events);
    // The mask only gates the line; flags set first would fire at once.
    irq_nxt  = sum_nxt & mask_nxt;
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // One read at a time; the answer stands until the master takes it.
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = '0;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_PIN_LEVELS:  rdata_nxt[PIN_W-1:0] = port_read;
        OFS_DIRECTION:   rdata_nxt[PIN_W-1:0] = dir_r;
        OFS_LATCH:       rdata_nxt[PIN_W-1:0] = lat_r;
        OFS_OPEN_DRAIN:  rdata_nxt[PIN_W-1:0] = od_r;
        OFS_SLEW_LIMIT:  rdata_nxt[PIN_W-1:0] = slew_r;
        OFS_ANALOG_SEL:  rdata_nxt[PIN_W-1:0] = ana_r;
        OFS_RISE_EN:     rdata_nxt[PIN_W-1:0] = rise_r;
        OFS_FALL_EN:     rdata_nxt[PIN_W-1:0] = fall_r;
        OFS_CHANGE_FLAG: rdata_nxt[PIN_W-1:0] = flag_r;
        OFS_INT_STATUS:  rdata_nxt[INT_SUMMARY_BIT] = sum_r;
        OFS_INT_MASK:    rdata_nxt[INT_SUMMARY_BIT] = mask_r;
        default:         rresp_nxt = RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Every control bit has a fixed value out of reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dir_r     <= RST_DIRECTION;
      lat_r     <= RST_LATCH;
      od_r      <= RST_OPEN_DRAIN;
      slew_r    <= RST_SLEW_LIMIT;
      ana_r     <= RST_ANALOG_SEL;
      rise_r    <= RST_EDGE_EN;
      fall_r    <= RST_EDGE_EN;
      flag_r    <= RST_FLAGS;
      sum_r     <= RST_INT_BIT;
      mask_r    <= RST_INT_BIT;
      irq_r     <= RST_INT_BIT;
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_full_r  <= 1'b0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      dir_r     <= dir_nxt;
      lat_r     <= lat_nxt;
      od_r      <= od_nxt;
      slew_r    <= slew_nxt;
      ana_r     <= ana_nxt;
      rise_r    <= rise_nxt;
      fall_r    <= fall_nxt;
      flag_r    <= flag_nxt;
      sum_r     <= sum_nxt;
      mask_r    <= mask_nxt;
      irq_r     <= irq_nxt;
      aw_full_r <= aw_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_full_r  <= w_full_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // Bus outputs straight from flip-flops.
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign irq           = irq_r;

endmodule : gpcd_port
